/* rtl/ulm_pkg.sv */
package ulm_pkg;
    // register offsets, byte addresses on the register port
    localparam logic [7:0] LINE_CTRL_OFS  = 8'h0c;
    localparam logic [7:0] MODEM_CTRL_OFS = 8'h10;

    // line_ctrl_reg field positions
    localparam int LCR_DIV_ACCESS_POS = 7;
    localparam int LCR_BREAK_POS      = 6;
    localparam int LCR_EVEN_POS       = 4;
    localparam int LCR_PARITY_POS     = 3;
    localparam int LCR_STOP_POS       = 2;
    localparam int LCR_WIDTH_LSB      = 0;

    // modem_ctrl_reg field positions
    localparam int MCR_IR_POS    = 6;
    localparam int MCR_FLOW_POS  = 5;
    localparam int MCR_LOOP_POS  = 4;
    localparam int MCR_OUT_B_POS = 3;
    localparam int MCR_OUT_A_POS = 2;
    localparam int MCR_RTS_POS   = 1;
    localparam int MCR_DTR_POS   = 0;

    // reset values
    localparam logic [7:0] LCR_RESET = 8'h00;
    localparam logic [6:0] MCR_RESET = 7'h00;

    // timing in 16x baud ticks
    localparam logic [3:0] LAST_TICK       = 4'hf;  // last tick of a bit
    localparam logic [3:0] MID_START_TICK  = 4'h7;  // middle of start bit
    localparam logic [5:0] STOP_ONE_TICKS  = 6'h10; // one stop bit
    localparam logic [5:0] STOP_HALF_TICKS = 6'h18; // one and a half
    localparam logic [5:0] STOP_TWO_TICKS  = 6'h20; // two stop bits
    localparam logic [3:0] SIR_PULSE_TICKS = 4'h3;  // 3/16 bit pulse
    localparam logic [4:0] SIR_HOLD_TICKS  = 5'h10; // decoded zero length

    // serial framer states
    typedef enum logic [2:0] {
        ULM_IDLE   = 3'b000,
        ULM_START  = 3'b001,
        ULM_DATA   = 3'b010,
        ULM_PARITY = 3'b011,
        ULM_STOP   = 3'b100
    } ulm_state_t;
endpackage : ulm_pkg

/* rtl/ulm_cfg_if.sv */
`timescale 1ns/1ps
interface ulm_cfg_if;
    logic [1:0] char_width;     // 00..11 gives 5..8 data bits
    logic       parity_on;      // parity_on_flag
    logic       even_parity;    // parity polarity
    logic       stop_sel;       // stop count select
    logic       send_break;     // break control
    logic       div_access;     // divisor access bit
    logic       ir_on;          // infrared mode
    logic       flow_on;        // automatic flow control
    logic       loop_on;        // loopback
    logic       out_b;          // user_output_b
    logic       out_a;          // user_output_a
    logic       rts_drive;      // request-to-send drive
    logic       dtr_drive;      // terminal ready drive
    logic       busy;           // framer activity

    modport regs (output char_width, parity_on, even_parity, stop_sel, send_break,
                  div_access, ir_on, flow_on, loop_on, out_b, out_a, rts_drive,
                  dtr_drive, input busy);
    modport core (input char_width, parity_on, even_parity, stop_sel, send_break,
                  div_access, ir_on, flow_on, loop_on, out_b, out_a, rts_drive,
                  dtr_drive, output busy);
    modport sir  (input ir_on, loop_on, send_break);
endinterface : ulm_cfg_if

/* rtl/ulm_regs.sv */
`timescale 1ns/1ps
module ulm_regs (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    // register port
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    // configuration out
    ulm_cfg_if.regs          cfg
);
    logic [7:0] line_ctrl_reg;   // line format
    logic [6:0] modem_ctrl_reg;  // modem control

    // line format register; format fields frozen while busy
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            line_ctrl_reg <= ulm_pkg::LCR_RESET;
        end else if (reg_wr_i && reg_addr_i == ulm_pkg::LINE_CTRL_OFS) begin
            // break is always writable, a stuck line must be releasable
            line_ctrl_reg[ulm_pkg::LCR_BREAK_POS] <= reg_wdata_i[ulm_pkg::LCR_BREAK_POS];
            if (!cfg.busy) begin
                line_ctrl_reg[ulm_pkg::LCR_DIV_ACCESS_POS] <=
                    reg_wdata_i[ulm_pkg::LCR_DIV_ACCESS_POS];
                line_ctrl_reg[ulm_pkg::LCR_EVEN_POS]   <= reg_wdata_i[ulm_pkg::LCR_EVEN_POS];
                line_ctrl_reg[ulm_pkg::LCR_PARITY_POS] <= reg_wdata_i[ulm_pkg::LCR_PARITY_POS];
                line_ctrl_reg[ulm_pkg::LCR_STOP_POS]   <= reg_wdata_i[ulm_pkg::LCR_STOP_POS];
                line_ctrl_reg[1:0] <= reg_wdata_i[ulm_pkg::LCR_WIDTH_LSB +: 2];
            end
        end
    end

    // modem control register, every bit writable at any time
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            modem_ctrl_reg <= ulm_pkg::MCR_RESET;
        end else if (reg_wr_i && reg_addr_i == ulm_pkg::MODEM_CTRL_OFS) begin
            modem_ctrl_reg <= reg_wdata_i[6:0];
        end
    end

    // read data, one cycle after the read strobe; reserved bits zero
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == ulm_pkg::LINE_CTRL_OFS) begin
                reg_rdata_o <= {24'h00_0000, line_ctrl_reg & 8'hdf};
            end else if (reg_addr_i == ulm_pkg::MODEM_CTRL_OFS) begin
                reg_rdata_o <= {25'h000_0000, modem_ctrl_reg};
            end else begin
                reg_rdata_o <= 32'h0000_0000; // unmapped reads zero
            end
        end
    end

    // field fan-out
    assign cfg.char_width  = line_ctrl_reg[1:0];
    assign cfg.stop_sel    = line_ctrl_reg[ulm_pkg::LCR_STOP_POS];
    assign cfg.parity_on   = line_ctrl_reg[ulm_pkg::LCR_PARITY_POS];
    assign cfg.even_parity = line_ctrl_reg[ulm_pkg::LCR_EVEN_POS];
    assign cfg.send_break  = line_ctrl_reg[ulm_pkg::LCR_BREAK_POS];
    assign cfg.div_access  = line_ctrl_reg[ulm_pkg::LCR_DIV_ACCESS_POS];
    assign cfg.ir_on       = modem_ctrl_reg[ulm_pkg::MCR_IR_POS];
    assign cfg.flow_on     = modem_ctrl_reg[ulm_pkg::MCR_FLOW_POS];
    assign cfg.loop_on     = modem_ctrl_reg[ulm_pkg::MCR_LOOP_POS];
    assign cfg.out_b       = modem_ctrl_reg[ulm_pkg::MCR_OUT_B_POS];
    assign cfg.out_a       = modem_ctrl_reg[ulm_pkg::MCR_OUT_A_POS];
    assign cfg.rts_drive   = modem_ctrl_reg[ulm_pkg::MCR_RTS_POS];
    assign cfg.dtr_drive   = modem_ctrl_reg[ulm_pkg::MCR_DTR_POS];
endmodule : ulm_regs

/* rtl/ulm_sir.sv */
`timescale 1ns/1ps
module ulm_sir (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    // timing from the transmitter
    input  wire logic       tick_i,
    input  wire logic [3:0] phase_i,
    input  wire logic       line_i,
    // infrared pins
    input  wire logic       ir_rx_low_i,
    output logic            ir_tx_low_o,
    // decoded receive level
    output logic            ir_line_o,
    // configuration
    ulm_cfg_if.sir          cfg
);
    logic [4:0] hold_cnt;  // ticks left of a decoded zero
    logic       pulse;     // encoder pulse window

    // a zero bit becomes a short pulse at the start of the bit time
    assign pulse = !line_i && (phase_i < ulm_pkg::SIR_PULSE_TICKS);

    // transmit pin, active low
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ir_tx_low_o <= 1'b1;
        end else if (cfg.loop_on) begin
            ir_tx_low_o <= !cfg.send_break;
        end else if (cfg.ir_on) begin
            // held break line pulses every bit time
            ir_tx_low_o <= !pulse;
        end else begin
            ir_tx_low_o <= 1'b1;
        end
    end

    // decoder stretches each received pulse to a full zero bit
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            hold_cnt <= 5'h00;
        end else if (!ir_rx_low_i && cfg.ir_on && !cfg.loop_on) begin
            hold_cnt <= ulm_pkg::SIR_HOLD_TICKS;
        end else if (tick_i && hold_cnt != 5'h00) begin
            hold_cnt <= hold_cnt - 5'h01;
        end
    end

    assign ir_line_o = (hold_cnt == 5'h00);
endmodule : ulm_sir

/* rtl/ulm_core.sv */
`timescale 1ns/1ps
module ulm_core (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    // register port
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    // 16x baud enable from the divider
    input  wire logic        baud_tick_i,
    // transmit characters
    input  wire logic [7:0]  tx_data_i,
    input  wire logic        tx_valid_i,
    output logic             tx_ready_o,
    // received characters
    output logic      [7:0]  rx_data_o,
    output logic             rx_valid_o,
    output logic             rx_parity_err_o,
    output logic             rx_frame_err_o,
    output logic             rx_break_o,
    input  wire logic        rx_at_trigger_i,
    // serial pins
    output logic             serial_tx_o,
    input  wire logic        serial_rx_i,
    output logic             ir_tx_low_o,
    input  wire logic        ir_rx_low_i,
    // modem pins
    output logic             rts_low_o,
    output logic             dtr_low_o,
    output logic             user_pin_a_low_o,
    output logic             user_pin_b_low_o,
    // status
    output logic             busy_o,
    output logic             div_access_o
);
    ulm_cfg_if cfg ();

    ulm_pkg::ulm_state_t tx_state;   // transmit framer
    ulm_pkg::ulm_state_t rx_state;   // receive framer
    logic [3:0] tx_phase;            // tick within a bit, restarts at each start bit
    logic [2:0] tx_bitn;             // data bit index
    logic [7:0] tx_shift;            // outgoing data
    logic       tx_par;              // running xor of sent bits
    logic [5:0] tx_stop_cnt;         // ticks spent in stop
    logic       tx_line;             // framer output level
    logic       eff_line;            // level after break
    logic [5:0] stop_ticks;          // configured stop length
    logic [2:0] last_bit;            // index of last data bit
    logic [3:0] rx_cnt;              // tick within a bit
    logic [2:0] rx_bitn;             // received bit index
    logic [7:0] rx_shift;            // incoming data
    logic       rx_par;              // running xor of received bits
    logic       rx_par_bad;          // parity mismatch seen
    logic       rx_any_one;          // any one level in the frame
    logic       rx_line;             // selected receive source
    logic       ir_line;             // decoded infrared level
    logic       rts_active;          // request-to-send wanted

    ulm_regs u_regs (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .reg_wr_i    (reg_wr_i),
        .reg_rd_i    (reg_rd_i),
        .reg_addr_i  (reg_addr_i),
        .reg_wdata_i (reg_wdata_i),
        .reg_rdata_o (reg_rdata_o),
        .cfg         (cfg)
    );

    ulm_sir u_sir (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .tick_i      (baud_tick_i),
        .phase_i     (tx_phase),
        .line_i      (eff_line),
        .ir_rx_low_i (ir_rx_low_i),
        .ir_tx_low_o (ir_tx_low_o),
        .ir_line_o   (ir_line),
        .cfg         (cfg)
    );

    // last data bit index is width code plus four
    assign last_bit = 3'h4 + {1'b0, cfg.char_width};

    // stop length: 1.5 only for five-bit characters
    always_comb begin
        if (!cfg.stop_sel) begin
            stop_ticks = ulm_pkg::STOP_ONE_TICKS;
        end else if (cfg.char_width == 2'h0) begin
            stop_ticks = ulm_pkg::STOP_HALF_TICKS;
        end else begin
            stop_ticks = ulm_pkg::STOP_TWO_TICKS;
        end
    end

    // accept a character only when idle
    assign tx_ready_o = (tx_state == ulm_pkg::ULM_IDLE);

    // phase counter; restarts with each start bit to align bit edges
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tx_phase <= 4'h0;
        end else if (tx_valid_i && tx_ready_o) begin
            tx_phase <= 4'h0;
        end else if (baud_tick_i) begin
            tx_phase <= tx_phase + 4'h1;
        end
    end

    // transmit framer: start, data lsb first, parity, stop
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tx_state    <= ulm_pkg::ULM_IDLE;
            tx_line     <= 1'b1;
            tx_shift    <= 8'h00;
            tx_bitn     <= 3'h0;
            tx_par      <= 1'b0;
            tx_stop_cnt <= 6'h00;
        end else begin
            case (tx_state)
                ulm_pkg::ULM_IDLE: begin
                    if (tx_valid_i) begin
                        tx_state <= ulm_pkg::ULM_START;
                        tx_shift <= tx_data_i;
                        tx_line  <= 1'b0;
                        tx_bitn  <= 3'h0;
                        tx_par   <= 1'b0;
                    end
                end
                ulm_pkg::ULM_START: begin
                    // first data bit goes out when the start bit ends
                    if (baud_tick_i && tx_phase == ulm_pkg::LAST_TICK) begin
                        tx_state <= ulm_pkg::ULM_DATA;
                        tx_line  <= tx_shift[0];
                        tx_par   <= tx_shift[0];
                        tx_shift <= {1'b0, tx_shift[7:1]};
                    end
                end
                ulm_pkg::ULM_DATA: begin
                    if (baud_tick_i && tx_phase == ulm_pkg::LAST_TICK) begin
                        if (tx_bitn != last_bit) begin
                            tx_bitn  <= tx_bitn + 3'h1;
                            tx_line  <= tx_shift[0];
                            tx_par   <= tx_par ^ tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[7:1]};
                        end else if (cfg.parity_on) begin
                            tx_state <= ulm_pkg::ULM_PARITY;
                            // even polarity makes the total count of ones even
                            tx_line  <= cfg.even_parity ? tx_par : !tx_par;
                        end else begin
                            tx_state    <= ulm_pkg::ULM_STOP;
                            tx_line     <= 1'b1;
                            tx_stop_cnt <= 6'h00;
                        end
                    end
                end
                ulm_pkg::ULM_PARITY: begin
                    if (baud_tick_i && tx_phase == ulm_pkg::LAST_TICK) begin
                        tx_state    <= ulm_pkg::ULM_STOP;
                        tx_line     <= 1'b1;
                        tx_stop_cnt <= 6'h00;
                    end
                end
                ulm_pkg::ULM_STOP: begin
                    // stop length counted in ticks so half bits fit
                    if (baud_tick_i) begin
                        if (tx_stop_cnt == stop_ticks - 6'h01) begin
                            tx_state <= ulm_pkg::ULM_IDLE;
                        end else begin
                            tx_stop_cnt <= tx_stop_cnt + 6'h01;
                        end
                    end
                end
                default: begin
                    tx_state <= ulm_pkg::ULM_IDLE;
                    tx_line  <= 1'b1;
                end
            endcase
        end
    end

    // break forces spacing on the framed level
    assign eff_line = cfg.send_break ? 1'b0 : tx_line;

    // serial pin; idles high in loopback and in infrared mode
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            serial_tx_o <= 1'b1;
        end else if (cfg.loop_on) begin
            serial_tx_o <= 1'b1;
        end else if (cfg.ir_on) begin
            serial_tx_o <= 1'b1;
        end else begin
            serial_tx_o <= eff_line;
        end
    end

    // receive source: own transmitter, infrared decoder or pin
    always_comb begin
        if (cfg.loop_on) begin
            rx_line = eff_line;
        end else if (cfg.ir_on) begin
            rx_line = ir_line;
        end else begin
            rx_line = serial_rx_i;
        end
    end

    // receive framer; samples at mid bit from the start edge
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rx_state   <= ulm_pkg::ULM_IDLE;
            rx_cnt     <= 4'h0;
            rx_bitn    <= 3'h0;
            rx_shift   <= 8'h00;
            rx_par     <= 1'b0;
            rx_par_bad <= 1'b0;
            rx_any_one <= 1'b0;
        end else if (baud_tick_i) begin
            case (rx_state)
                ulm_pkg::ULM_IDLE: begin
                    if (!rx_line) begin
                        rx_state <= ulm_pkg::ULM_START;
                        rx_cnt   <= 4'h0;
                    end
                end
                ulm_pkg::ULM_START: begin
                    // glitch shorter than half a bit is dropped
                    if (rx_cnt == ulm_pkg::MID_START_TICK) begin
                        rx_state   <= rx_line ? ulm_pkg::ULM_IDLE : ulm_pkg::ULM_DATA;
                        rx_cnt     <= 4'h0;
                        rx_bitn    <= 3'h0;
                        rx_par     <= 1'b0;
                        rx_par_bad <= 1'b0;
                        rx_any_one <= 1'b0;
                    end else begin
                        rx_cnt <= rx_cnt + 4'h1;
                    end
                end
                ulm_pkg::ULM_DATA: begin
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == ulm_pkg::LAST_TICK) begin
                        rx_shift   <= {rx_line, rx_shift[7:1]};
                        rx_par     <= rx_par ^ rx_line;
                        rx_any_one <= rx_any_one | rx_line;
                        rx_bitn    <= rx_bitn + 3'h1;
                        if (rx_bitn == last_bit) begin
                            rx_state <= cfg.parity_on ? ulm_pkg::ULM_PARITY
                                                      : ulm_pkg::ULM_STOP;
                        end
                    end
                end
                ulm_pkg::ULM_PARITY: begin
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == ulm_pkg::LAST_TICK) begin
                        rx_state   <= ulm_pkg::ULM_STOP;
                        rx_any_one <= rx_any_one | rx_line;
                        rx_par_bad <= (rx_line != (cfg.even_parity ? rx_par : !rx_par));
                    end
                end
                ulm_pkg::ULM_STOP: begin
                    // only the first stop bit is looked at
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == ulm_pkg::LAST_TICK) begin
                        rx_state <= ulm_pkg::ULM_IDLE;
                    end
                end
                default: begin
                    rx_state <= ulm_pkg::ULM_IDLE;
                end
            endcase
        end
    end

    // character out at the first stop sample
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rx_valid_o      <= 1'b0;
            rx_data_o       <= 8'h00;
            rx_parity_err_o <= 1'b0;
            rx_frame_err_o  <= 1'b0;
            rx_break_o      <= 1'b0;
        end else if (baud_tick_i && rx_state == ulm_pkg::ULM_STOP
                     && rx_cnt == ulm_pkg::LAST_TICK) begin
            rx_valid_o      <= 1'b1;
            // short characters were shifted in from the top
            rx_data_o       <= rx_shift >> (2'h3 - cfg.char_width);
            rx_parity_err_o <= rx_par_bad && cfg.parity_on;
            rx_frame_err_o  <= !rx_line;
            rx_break_o      <= !rx_any_one && !rx_line;
        end else begin
            rx_valid_o <= 1'b0;
        end
    end

    // busy while either framer is inside a character
    assign cfg.busy = (tx_state != ulm_pkg::ULM_IDLE) || (rx_state != ulm_pkg::ULM_IDLE);

    // flow control drops the request once the buffer hits its trigger
    assign rts_active = cfg.rts_drive && !(cfg.flow_on && rx_at_trigger_i);

    // modem pins, all active low, registered to avoid glitches
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rts_low_o        <= 1'b1;
            dtr_low_o        <= 1'b1;
            user_pin_a_low_o <= 1'b1;
            user_pin_b_low_o <= 1'b1;
        end else begin
            rts_low_o        <= !rts_active;
            dtr_low_o        <= !cfg.dtr_drive;
            user_pin_a_low_o <= !cfg.out_a;
            user_pin_b_low_o <= !cfg.out_b;
        end
    end

    // status outputs
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            busy_o       <= 1'b0;
            div_access_o <= 1'b0;
        end else begin
            busy_o       <= cfg.busy;
            div_access_o <= cfg.div_access;
        end
    end
endmodule : ulm_core

/* testbench/ulm_core_asserts.sv */
`timescale 1ns/1ps
module ulm_core_asserts (
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        srst_i,
    // watched ports
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        tx_valid_i,
    input wire logic        tx_ready_o,
    input wire logic        serial_tx_o,
    input wire logic        ir_tx_low_o,
    input wire logic        rts_low_o,
    input wire logic        dtr_low_o,
    input wire logic        user_pin_a_low_o,
    input wire logic        user_pin_b_low_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    logic brk, lp, ir;                          // shadow break, loopback, infrared
    wire  mw = reg_wr_i && reg_addr_i == 8'h10; // modem register write
    // shadow copy, break bit is never refused
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) {brk, lp, ir} <= 3'h0;
        else begin
            if (reg_wr_i && reg_addr_i == 8'h0c) brk <= reg_wdata_i[6];
            if (mw) {ir, lp} <= {reg_wdata_i[6], reg_wdata_i[4]};
        end
    end
    sequence brk_out_s; (brk && !lp && !ir) [*4]; endsequence
    sequence brk_loop_s; (brk && lp) [*4]; endsequence
    dtr_pin_a: assert property (mw |-> ##2 dtr_low_o != $past(reg_wdata_i[0], 2))
        else $error("dtr pin wrong");
    pin_a_a: assert property (mw |-> ##2 user_pin_a_low_o != $past(reg_wdata_i[2], 2))
        else $error("user pin a wrong");
    pin_b_a: assert property (mw |-> ##2 user_pin_b_low_o != $past(reg_wdata_i[3], 2))
        else $error("user pin b wrong");
    rts_pin_a: assert property (mw && !reg_wdata_i[5] |-> ##2 rts_low_o != $past(reg_wdata_i[1], 2))
        else $error("rts pin wrong");
    brk_line_a: assert property (brk_out_s |-> !serial_tx_o)
        else $error("break not held low");
    loop_brk_a: assert property (brk_loop_s |-> serial_tx_o && !ir_tx_low_o)
        else $error("loopback break leaked");
    ir_idle_a: assert property ((ir && !lp && !brk) [*4] |-> serial_tx_o)
        else $error("serial line active in infrared mode");
    start_bit_a: assert property (tx_valid_i && tx_ready_o && !brk && !lp && !ir |-> ##[1:2] !serial_tx_o)
        else $error("no start bit");
endmodule : ulm_core_asserts
bind ulm_core ulm_core_asserts chk (.*);

/* testbench/ulm_peer.sv */
`timescale 1ns/1ps
// far peer wired as an echo cable, idle level high before first edge
module ulm_peer (
    input  wire logic sys_clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    initial line_o = 1'b1;
    always @(posedge sys_clk_i) line_o <= line_i;
endmodule : ulm_peer

/* testbench/tb_ulm_core.sv */
`timescale 1ns/1ps
module tb_ulm_core;
    logic sys_clk_i, srst_i, reg_wr_i, reg_rd_i, tx_valid_i, rx_at_trigger_i, baud_tick_i;
    logic ir_rx_low_i, serial_rx_i, tx_ready_o, rx_valid_o, rx_parity_err_o, rx_frame_err_o;
    logic rx_break_o, serial_tx_o, ir_tx_low_o, rts_low_o, dtr_low_o, busy_o, div_access_o;
    logic user_pin_a_low_o, user_pin_b_low_o, pbit;
    logic [7:0]  reg_addr_i, tx_data_i, rx_data_o;
    logic [8:0]  got;                     // error flag and last character
    logic [31:0] reg_wdata_i, reg_rdata_o, seed, d;
    int          err_total, checked, n, t, k;
    ulm_core dut (.*);
    ulm_peer peer (.sys_clk_i(sys_clk_i), .line_i(serial_tx_o), .line_o(serial_rx_i));
    initial begin sys_clk_i = 0; forever #10 sys_clk_i = ~sys_clk_i; end
    // capture each received character with its error flags
    always @(posedge sys_clk_i) if (rx_valid_o) got <= {rx_parity_err_o | rx_frame_err_o, rx_data_o};
    function automatic logic [31:0] rnd();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // ticks run every cycle, so one tick is one cycle
    function automatic int frame_len(logic [3:0] f);
        return 16 * (6 + f[1:0] + f[3]) + (f[2] ? (f[1:0] == 0 ? 24 : 32) : 16);
    endfunction : frame_len
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin err_total++; $display("Error %s exp %h got %h", s, e, g); end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge sys_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
        @(posedge sys_clk_i) reg_wr_i <= 0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [31:0] e, string s);
        @(posedge sys_clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge sys_clk_i) reg_rd_i <= 0;
        @(negedge sys_clk_i) chk(s, e, reg_rdata_o);
    endtask : rd
    task automatic wrap_up();
        if (err_total == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial begin repeat (20000) @(posedge sys_clk_i); err_total++; wrap_up(); end
    initial begin
        {srst_i, reg_wr_i, reg_rd_i, tx_valid_i, rx_at_trigger_i, baud_tick_i, ir_rx_low_i} = 7'h43;
        {reg_addr_i, tx_data_i, reg_wdata_i, seed, err_total, checked} = {48'h0, 32'h102d, 64'h0};
        repeat (20) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        // random modem settings, flow control may hold rts off
        repeat (16) begin
            d = rnd();
            @(posedge sys_clk_i) rx_at_trigger_i <= d[8];
            wr(8'h10, d & 32'h7f);
            @(posedge sys_clk_i);
            @(negedge sys_clk_i) chk("dtr", 32'(!d[0]), 32'(dtr_low_o));
            chk("pin a", 32'(!d[2]), 32'(user_pin_a_low_o));
            chk("pin b", 32'(!d[3]), 32'(user_pin_b_low_o));
            chk("rts", 32'(!(d[1] && !(d[5] && d[8]))), 32'(rts_low_o));
            rd(8'h10, d & 32'h7f, "modem reg");
        end
        wr(8'h10, 32'h0);
        // every width, parity and stop choice, format write refused mid frame
        for (int c = 0; c < 16; c++) begin
            d = rnd();
            wr(8'h0c, 32'({d[4], c[3:0]}));
            @(posedge sys_clk_i) {tx_valid_i, tx_data_i} <= {1'b1, d[15:8]};
            @(posedge sys_clk_i) tx_valid_i <= 0;
            t = int'($time);
            wr(8'h0c, 32'({~d[4], ~c[3:0]}) | 32'h80);
            rd(8'h0c, 32'({d[4], c[3:0]}), "format busy");
            chk("busy div", 32'h2, 32'({busy_o, div_access_o}));
            while (tx_ready_o !== 1'b1 && int'($time) - t < 9000) begin
                @(negedge sys_clk_i);
                // middle of the parity bit, pin one cycle behind the framer
                if (int'($time) - t == 320 * (6 + c[1:0]) + 170) pbit = serial_tx_o;
            end
            n = (int'($time) - t) / 20;
            k = frame_len(c[3:0]);
            chk("frame cycles", k, (n >= k - 2 && n <= k + 2) ? k : n);
            k = ^{~d[4], d[15:8] & ~(8'hff << (5 + c[1:0]))};
            if (c[3]) chk("parity bit", k, 32'(pbit));
            repeat (40) @(posedge sys_clk_i);
            chk("rx char", 32'(d[15:8] & ~(8'hff << (5 + c[1:0]))), 32'(got));
        end
        wr(8'h0c, 32'h40);
        repeat (120) @(posedge sys_clk_i);
        @(negedge sys_clk_i) chk("break line", 32'h0, 32'(serial_tx_o));
        chk("break flag", 32'h1, 32'(rx_break_o));
        wr(8'h10, 32'h10);
        repeat (6) @(posedge sys_clk_i);
        @(negedge sys_clk_i) chk("loop break", 32'h2, 32'({serial_tx_o, ir_tx_low_o}));
        wr(8'h10, 32'h40);
        repeat (6) @(posedge sys_clk_i);
        k = 0;
        repeat (32) @(negedge sys_clk_i) k += int'(!ir_tx_low_o);
        chk("ir pulses", 32'd6, 32'(k));
        rd(8'h20, 32'h0, "unmapped");
        wrap_up();
    end
endmodule : tb_ulm_core
